// >>> logic/cpu_clk_switch_pkg.sv
// Shared constants and types for the CPU clock source switch.
// Assumes a single 100 MHz system clock and an 8-bit register write port.
package cpu_clk_switch_pkg;
  // System clock period
  localparam int CLK_PERIOD_NS = 10;
  // Internal high-speed oscillator settling time
  localparam int INT_OSC_SETTLE_NS = 500;
  localparam int INT_OSC_SETTLE_CYC = (INT_OSC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Subsystem crystal settling time
  localparam int SUB_OSC_SETTLE_NS = 20000;
  localparam int SUB_OSC_SETTLE_CYC = (SUB_OSC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Settling counter widths and terminal values
  localparam int INT_CNT_W = 8;
  localparam int SUB_CNT_W = 12;
  localparam logic [INT_CNT_W-1:0] INT_OSC_SETTLE_MAX = INT_CNT_W'(INT_OSC_SETTLE_CYC);
  localparam logic [SUB_CNT_W-1:0] SUB_OSC_SETTLE_MAX = SUB_CNT_W'(SUB_OSC_SETTLE_CYC);
  // Bit positions in main_clk_mode_reg
  localparam int MAIN_SRC_SEL_BIT = 0;
  localparam int PERIPH_SRC_SEL_BIT = 2;
  // Bit positions in osc_mode_select_reg
  localparam int SUB_EXT_CLK_SEL_BIT = 5;
  localparam int SUB_OSC_ENABLE_BIT = 4;
  // Bit positions in int_osc_mode_reg
  localparam int INT_OSC_STABLE_BIT = 7;
  localparam int INT_OSC_STOP_BIT = 0;
  // Bit positions in cpu_clk_ctrl_reg
  localparam int XTAL_SUB_START_BIT = 6;
  localparam int CPU_SUB_CLK_SEL_BIT = 4;
  // Values after reset
  localparam logic RST_MAIN_SRC_SEL = 1'b0;
  localparam logic RST_PERIPH_SRC_SEL = 1'b0;
  localparam logic RST_SUB_EXT_CLK_SEL = 1'b0;
  localparam logic RST_SUB_OSC_ENABLE = 1'b0;
  localparam logic RST_INT_OSC_STOP = 1'b0;
  localparam logic RST_XTAL_SUB_START = 1'b0;
  localparam logic RST_CPU_SUB_CLK_SEL = 1'b0;
  localparam logic [7:0] REG_ZERO = 8'h00;

  // Register write request: strobe plus byte
  typedef struct packed {
    logic wr;
    logic [7:0] data;
  } reg_wr_s;

  // CPU clock sources
  typedef enum logic [1:0] {
    SRC_INT = 2'h0,
    SRC_HS = 2'h1,
    SRC_SUB = 2'h3
  } clk_src_e;

  // Glitch-free switch sequence; one bit changes per step except SW_ARM_NEW back to SW_IDLE
  typedef enum logic [1:0] {
    SW_IDLE = 2'h0,
    SW_DRAIN_OLD = 2'h1,
    SW_ARM_NEW = 2'h3
  } sw_state_e;
endpackage : cpu_clk_switch_pkg

// >>> logic/cpu_clock_source_switch.sv
// CPU clock source switch: control registers, oscillator settling and source select.
// Assumes the three oscillator levels arrive synchronous to sys_clk and that
// software orders its writes as the switching sequences require.
// Notes on behaviour
// - Main source select at bit 0.
// - External select bit 5, enable bit 4.
// - Stable flag bit 7, stop bit 0.
// - Crystal start bit 6, sub select bit 4.
`timescale 1ns/100ps
module cpu_clock_source_switch (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Register writes
  input wire cpu_clk_switch_pkg::reg_wr_s main_clk_mode_wr,
  input wire cpu_clk_switch_pkg::reg_wr_s osc_mode_select_wr,
  input wire cpu_clk_switch_pkg::reg_wr_s int_osc_mode_wr,
  input wire cpu_clk_switch_pkg::reg_wr_s cpu_clk_ctrl_wr,
  // Register read values
  output logic [7:0] main_clk_mode_rd,
  output logic [7:0] osc_mode_select_rd,
  output logic [7:0] int_osc_mode_rd,
  output logic [7:0] cpu_clk_ctrl_rd,
  // Oscillator clock levels
  input wire logic int_osc_clk,
  input wire logic hs_sys_clk,
  input wire logic sub_clk,
  // Oscillator controls and status
  output logic int_osc_run_en,
  output logic sub_osc_run_en,
  output logic sub_ext_input_en,
  output logic sub_clk_stable,
  output logic periph_src_sel,
  // Selected CPU clock
  output logic cpu_clk_out,
  output logic [1:0] cpu_src_active
);
  import cpu_clk_switch_pkg::*;

  logic main_clk_src_sel_r; // 0 internal osc, 1 high-speed system clock
  logic periph_src_sel_r; // Peripheral source select
  logic sub_ext_clk_sel_r; // External subsystem input chosen
  logic sub_osc_enable_r; // Subsystem oscillator enable
  logic int_osc_stop_r; // Internal oscillator stopped
  logic int_osc_stable_r; // Internal oscillator settled
  logic xtal_sub_start_r; // Crystal start regardless of other bits
  logic cpu_sub_clk_sel_r; // CPU runs from subsystem clock
  logic sub_stable_r; // Subsystem clock settled
  logic [INT_CNT_W-1:0] int_cnt_r; // Internal osc settling count
  logic [SUB_CNT_W-1:0] sub_cnt_r; // Subsystem settling count
  sw_state_e sw_state_r; // Switch sequence state
  clk_src_e active_src_r; // Source now driving the CPU
  clk_src_e pend_src_r; // Source being switched to
  logic cpu_clk_r; // Registered CPU clock
  clk_src_e target_src; // Source the registers ask for
  logic sub_run; // Subsystem oscillator requested
  logic sub_ext_mode; // External input mode, no settling

  // Pick the level of one source
  function automatic logic src_level(input clk_src_e src, input logic l_int,
                                     input logic l_hs, input logic l_sub);
    logic lvl;
    lvl = l_int;
    if (src == SRC_HS) begin
      lvl = l_hs;
    end else if (src == SRC_SUB) begin
      lvl = l_sub;
    end
    return lvl;
  endfunction : src_level

  // Main clock mode register
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      main_clk_src_sel_r <= RST_MAIN_SRC_SEL;
      periph_src_sel_r <= RST_PERIPH_SRC_SEL;
    end else if (main_clk_mode_wr.wr) begin
      main_clk_src_sel_r <= main_clk_mode_wr.data[MAIN_SRC_SEL_BIT];
      periph_src_sel_r <= main_clk_mode_wr.data[PERIPH_SRC_SEL_BIT];
    end
  end

  // Oscillator mode select register
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sub_ext_clk_sel_r <= RST_SUB_EXT_CLK_SEL;
      sub_osc_enable_r <= RST_SUB_OSC_ENABLE;
    end else if (osc_mode_select_wr.wr) begin
      sub_ext_clk_sel_r <= osc_mode_select_wr.data[SUB_EXT_CLK_SEL_BIT];
      sub_osc_enable_r <= osc_mode_select_wr.data[SUB_OSC_ENABLE_BIT];
    end
  end

  // Internal oscillator stop bit; the stable flag is hardware only
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      int_osc_stop_r <= RST_INT_OSC_STOP;
    end else if (int_osc_mode_wr.wr) begin
      int_osc_stop_r <= int_osc_mode_wr.data[INT_OSC_STOP_BIT];
    end
  end

  // Processor clock control register
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      xtal_sub_start_r <= RST_XTAL_SUB_START;
      cpu_sub_clk_sel_r <= RST_CPU_SUB_CLK_SEL;
    end else if (cpu_clk_ctrl_wr.wr) begin
      xtal_sub_start_r <= cpu_clk_ctrl_wr.data[XTAL_SUB_START_BIT];
      cpu_sub_clk_sel_r <= cpu_clk_ctrl_wr.data[CPU_SUB_CLK_SEL_BIT];
    end
  end

  // Internal oscillator settling; a stop write drops the flag at once,
  // so a poll right after a restart can never see a stale 1
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      int_cnt_r <= '0;
      int_osc_stable_r <= 1'b0;
    end else if (int_osc_stop_r ||
                 (int_osc_mode_wr.wr && int_osc_mode_wr.data[INT_OSC_STOP_BIT])) begin
      int_cnt_r <= '0;
      int_osc_stable_r <= 1'b0;
    end else if (int_cnt_r != INT_OSC_SETTLE_MAX) begin
      int_cnt_r <= int_cnt_r + 1'b1;
      int_osc_stable_r <= 1'b0;
    end else begin
      int_osc_stable_r <= 1'b1;
    end
  end

  // Subsystem oscillator request decode
  always_comb begin
    sub_run = xtal_sub_start_r | sub_osc_enable_r;
    sub_ext_mode = !xtal_sub_start_r & sub_ext_clk_sel_r & sub_osc_enable_r;
  end

  // Subsystem settling counter
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sub_cnt_r <= '0;
      sub_stable_r <= 1'b0;
    end else if (!sub_run) begin
      sub_cnt_r <= '0;
      sub_stable_r <= 1'b0;
    end else if (sub_ext_mode) begin
      sub_stable_r <= 1'b1;
    end else if (sub_cnt_r != SUB_OSC_SETTLE_MAX) begin
      sub_cnt_r <= sub_cnt_r + 1'b1;
      sub_stable_r <= 1'b0;
    end else begin
      sub_stable_r <= 1'b1;
    end
  end

  // Requested source: the sub select wins over the main select
  always_comb begin
    target_src = SRC_INT;
    if (cpu_sub_clk_sel_r) begin
      target_src = SRC_SUB;
    end else if (main_clk_src_sel_r) begin
      target_src = SRC_HS;
    end
  end

  // Glitch-free switch: park low on the old source, then wait for the new
  // source to be low before following it, so no short pulse reaches the CPU.
  // A source held high stalls the switch; software must start it first.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sw_state_r <= SW_IDLE;
      active_src_r <= SRC_INT;
      pend_src_r <= SRC_INT;
    end else begin
      case (sw_state_r)
        SW_IDLE: begin
          if (target_src != active_src_r) begin
            pend_src_r <= target_src;
            sw_state_r <= SW_DRAIN_OLD;
          end
        end
        SW_DRAIN_OLD: begin
          if (!src_level(active_src_r, int_osc_clk, hs_sys_clk, sub_clk)) begin
            sw_state_r <= SW_ARM_NEW;
          end
        end
        SW_ARM_NEW: begin
          if (!src_level(pend_src_r, int_osc_clk, hs_sys_clk, sub_clk)) begin
            active_src_r <= pend_src_r;
            sw_state_r <= SW_IDLE;
          end
        end
        default: begin
          sw_state_r <= SW_IDLE;
        end
      endcase
    end
  end

  // CPU clock output register
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cpu_clk_r <= 1'b0;
    end else if (sw_state_r == SW_ARM_NEW) begin
      cpu_clk_r <= 1'b0;
    end else if (sw_state_r == SW_DRAIN_OLD && !cpu_clk_r) begin
      cpu_clk_r <= 1'b0;
    end else begin
      cpu_clk_r <= src_level(active_src_r, int_osc_clk, hs_sys_clk, sub_clk);
    end
  end

  // Read values and pins; reserved bits read as zero
  always_comb begin
    main_clk_mode_rd = REG_ZERO;
    main_clk_mode_rd[MAIN_SRC_SEL_BIT] = main_clk_src_sel_r;
    main_clk_mode_rd[PERIPH_SRC_SEL_BIT] = periph_src_sel_r;
    osc_mode_select_rd = REG_ZERO;
    osc_mode_select_rd[SUB_EXT_CLK_SEL_BIT] = sub_ext_clk_sel_r;
    osc_mode_select_rd[SUB_OSC_ENABLE_BIT] = sub_osc_enable_r;
    int_osc_mode_rd = REG_ZERO;
    int_osc_mode_rd[INT_OSC_STABLE_BIT] = int_osc_stable_r;
    int_osc_mode_rd[INT_OSC_STOP_BIT] = int_osc_stop_r;
    cpu_clk_ctrl_rd = REG_ZERO;
    cpu_clk_ctrl_rd[XTAL_SUB_START_BIT] = xtal_sub_start_r;
    cpu_clk_ctrl_rd[CPU_SUB_CLK_SEL_BIT] = cpu_sub_clk_sel_r;
  end

  assign int_osc_run_en = !int_osc_stop_r;
  assign sub_osc_run_en = sub_run & !sub_ext_mode;
  assign sub_ext_input_en = sub_ext_mode;
  assign sub_clk_stable = sub_stable_r;
  assign periph_src_sel = periph_src_sel_r;
  assign cpu_clk_out = cpu_clk_r;
  assign cpu_src_active = active_src_r;

  // Checks
  AST_MAIN_SEL_BIT: assert property (@(posedge sys_clk) disable iff (!reset_n)
    main_clk_mode_wr.wr |=> main_clk_mode_rd[0] == $past(main_clk_mode_wr.data[0]))
    else $error("main source select not at bit 0");
  AST_OSC_MODE_BITS: assert property (@(posedge sys_clk) disable iff (!reset_n)
    osc_mode_select_wr.wr |=> osc_mode_select_rd[5:4] == $past(osc_mode_select_wr.data[5:4]))
    else $error("subsystem mode bits not at 5 and 4");
  AST_STOP_DROPS_FLAG: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (int_osc_mode_wr.wr && int_osc_mode_wr.data[0]) |=>
      (int_osc_mode_rd[7] == 1'b0 && int_osc_mode_rd[0] == 1'b1))
    else $error("stop write did not show at bits 0 and 7");
  AST_PCC_BITS: assert property (@(posedge sys_clk) disable iff (!reset_n)
    cpu_clk_ctrl_wr.wr |=> (cpu_clk_ctrl_rd[6] == $past(cpu_clk_ctrl_wr.data[6]) &&
      cpu_clk_ctrl_rd[4] == $past(cpu_clk_ctrl_wr.data[4])))
    else $error("crystal start or sub select misplaced");
  AST_STABLE_SETTLED: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(int_osc_stable_r) |-> (int_cnt_r == INT_OSC_SETTLE_MAX && !$past(int_osc_stop_r, 2)))
    else $error("stable flag rose before settling");
  AST_PARK_LOW: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (sw_state_r == SW_ARM_NEW) |=> !cpu_clk_r)
    else $error("CPU clock high while arming new source");
  AST_EXT_NO_WAIT: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (sub_ext_mode && $past(sub_ext_mode)) |-> sub_stable_r)
    else $error("external subclock not stable at once");
endmodule : cpu_clock_source_switch

// >>> verification/tb_top.sv
// Self-checking testbench for the CPU clock source switch: register writes,
// read-back, oscillator settling and CPU source selection at the ports.
// Assumes the design package is compiled first; the bench drives every input itself.
`timescale 1ns/100ps
module tb_top;
  import cpu_clk_switch_pkg::*;
  // Register slots in the write and read arrays
  localparam int R_MAIN = 0;
  localparam int R_OSC = 1;
  localparam int R_INT = 2;
  localparam int R_CPU = 3;
  // Clock, reset and result counters
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  int fail_count = 0;
  int checked = 0;
  int n;
  // Write requests and read values, one slot per register
  reg_wr_s wr_req [4] = '{default: '0};
  logic [7:0] rd_val [4];
  // Oscillator levels at unlike rates, so each source drops low often
  logic [3:0] osc_cnt = 4'h0;
  // Design outputs
  logic int_osc_run_en;
  logic sub_osc_run_en;
  logic sub_ext_input_en;
  logic sub_clk_stable;
  logic periph_src_sel;
  logic cpu_clk_out;
  logic [1:0] cpu_src_active;

  // System clock, 10 ns period
  always #5 sys_clk = ~sys_clk;

  // Oscillator levels move just after the edge, like every other input
  always @(posedge sys_clk) begin
    #1;
    osc_cnt <= osc_cnt + 4'h1;
  end

  cpu_clock_source_switch dut (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .main_clk_mode_wr(wr_req[R_MAIN]),
    .osc_mode_select_wr(wr_req[R_OSC]),
    .int_osc_mode_wr(wr_req[R_INT]),
    .cpu_clk_ctrl_wr(wr_req[R_CPU]),
    .main_clk_mode_rd(rd_val[R_MAIN]),
    .osc_mode_select_rd(rd_val[R_OSC]),
    .int_osc_mode_rd(rd_val[R_INT]),
    .cpu_clk_ctrl_rd(rd_val[R_CPU]),
    .int_osc_clk(osc_cnt[1]),
    .hs_sys_clk(osc_cnt[2]),
    .sub_clk(osc_cnt[3]),
    .int_osc_run_en(int_osc_run_en),
    .sub_osc_run_en(sub_osc_run_en),
    .sub_ext_input_en(sub_ext_input_en),
    .sub_clk_stable(sub_clk_stable),
    .periph_src_sel(periph_src_sel),
    .cpu_clk_out(cpu_clk_out),
    .cpu_src_active(cpu_src_active)
  );

  // One-cycle write pulse; read value is valid when the task returns
  task automatic write_reg(input int idx, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    wr_req[idx] = '{wr: 1'b1, data: d};
    @(posedge sys_clk);
    #1;
    wr_req[idx].wr = 1'b0;
  endtask : write_reg

  // Compare one byte, count it, report a mismatch at once
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Count cycles until a status bit rises: sel 0 is the stable flag, 1 the subclock
  task automatic wait_bit(input int sel, output int cnt);
    cnt = 0;
    while (((sel == 0) ? rd_val[R_INT][7] : sub_clk_stable) !== 1'b1 && cnt < 2100) begin
      @(posedge sys_clk);
      #1;
      cnt++;
    end
  endtask : wait_bit

  // Bounded wait for the switch to settle on a source, then compare it
  task automatic wait_src(input clk_src_e e);
    int k;
    logic lvl;
    k = 0;
    lvl = 1'b0;
    while (cpu_src_active !== e && k < 100) begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    chk({6'h0, cpu_src_active}, {6'h0, e});
    // output follows new source
    // Level taken at the edge, where it is settled, and compared once the output moved
    repeat (8) begin
      @(posedge sys_clk);
      lvl = (e == SRC_INT) ? osc_cnt[1] : ((e == SRC_HS) ? osc_cnt[2] : osc_cnt[3]);
      #1;
      chk({7'h0, cpu_clk_out}, {7'h0, lvl});
    end
  endtask : wait_src

  // Verdict and end of run
  task automatic end_of_test();
    if (fail_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test

  // Watchdog, well beyond the roughly 2200 cycles the tests take
  initial begin
    #100000;
    fail_count++;
    $display("ERROR %0t: watchdog expired", $time);
    end_of_test();
  end

  // Main sequence
  initial begin
    repeat (5) @(posedge sys_clk);
    // Outputs are looked at off the edge, where they have settled
    #1;
    for (int i = 0; i < 4; i++) chk(rd_val[i], REG_ZERO);
    chk({7'h0, int_osc_run_en}, 8'h01);
    chk({6'h0, cpu_src_active}, {6'h0, SRC_INT});
    chk({7'h0, cpu_clk_out}, 8'h00);
    reset_n = 1'b1;
    wait_bit(0, n);
    chk({7'h0, (n >= 49 && n <= 53)}, 8'h01);
    // stop clears flag, restart settles again
    write_reg(R_INT, 8'h81);
    chk(rd_val[R_INT], 8'h01);
    chk({7'h0, int_osc_run_en}, 8'h00);
    write_reg(R_INT, 8'h00);
    wait_bit(0, n);
    chk({7'h0, (n >= 47 && n <= 53)}, 8'h01);
    // main select to high-speed, periph bit alongside
    write_reg(R_MAIN, 8'h05);
    chk(rd_val[R_MAIN], 8'h05);
    chk({7'h0, periph_src_sel}, 8'h01);
    wait_src(SRC_HS);
    write_reg(R_MAIN, 8'h00);
    wait_src(SRC_INT);
    write_reg(R_OSC, 8'hFF);
    chk(rd_val[R_OSC], 8'h30);
    chk({6'h0, sub_ext_input_en, sub_osc_run_en}, 8'h02);
    wait_bit(1, n);
    chk({7'h0, (n <= 2)}, 8'h01);
    write_reg(R_CPU, 8'h10);
    chk(rd_val[R_CPU], 8'h10);
    wait_src(SRC_SUB);
    // back to internal, periph bit already zero
    write_reg(R_CPU, 8'h00);
    wait_src(SRC_INT);
    write_reg(R_OSC, 8'h00);
    // The settled flag drops one edge after the enables clear
    @(posedge sys_clk);
    #1;
    chk({7'h0, sub_clk_stable}, 8'h00);
    write_reg(R_CPU, 8'h40);
    chk({6'h0, sub_ext_input_en, sub_osc_run_en}, 8'h01);
    wait_bit(1, n);
    chk({7'h0, (n >= 1995 && n <= 2005)}, 8'h01);
    write_reg(R_CPU, 8'h50);
    chk(rd_val[R_CPU], 8'h50);
    wait_src(SRC_SUB);
    end_of_test();
  end
endmodule : tb_top
